/* src/cm_memory.sv */
// connection memory: low and high word per entry, registered read data
`timescale 1ns/1ps
`include "ims_regs.svh"
module cm_memory (
  input wire logic pclk,
  input wire logic [`CM_AW-1:0] addr,
  input wire logic we_low,
  input wire logic we_high,
  input wire logic [`CM_DW-1:0] wdata_low,
  input wire logic [`CM_DW-1:0] wdata_high,
  output logic [`CM_DW-1:0] rdata_low,
  output logic [`CM_DW-1:0] rdata_high
);
  import mode_sel_pkg::*;
  logic [`CM_DW-1:0] mem_low [`CM_DEPTH];
  logic [`CM_DW-1:0] mem_high [`CM_DEPTH];

  always_ff @(posedge pclk) begin
    if (we_low) begin
      mem_low[addr] <= wdata_low;
    end
    if (we_high) begin
      mem_high[addr] <= wdata_high;
    end
    rdata_low <= mem_low[addr];
    rdata_high <= mem_high[addr];
  end
endmodule

/* src/ims_pkg.sv */
// types shared by the mode select block
package mode_sel_pkg;
  typedef enum logic [1:0] {FILL_IDLE, FILL_RUN, FILL_HOLD} fill_state_t;
  typedef logic [15:0] word_t;
  typedef logic [31:0] stream_vec_t;
endpackage

/* src/ims_regs.svh */
// register map, field positions and timing counts of the mode select block
`ifndef MODE_SEL_REGS_SVH
`define MODE_SEL_REGS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_MODE_SEL 16'h0000
`define ADDR_CTRL 16'h0004
`define ADDR_STATUS 16'h0008
// connection memory window: paddr[15] set, paddr[14] picks the high word, paddr[13:2] the entry
`define CM_WIN_BIT 15
`define CM_HIGH_BIT 14
`define CM_IDX_MSB 13
`define CM_IDX_LSB 2

// ------------------------------------------------------------
// mode select fields
// ------------------------------------------------------------
`define MS_START_BIT 0
`define MS_VALUE_LSB 1
`define MS_VALUE_MSB 3
`define MS_TX_EN_BIT 4
`define MS_RX_EN_BIT 5
`define MS_LOWER_BIT 6
`define MS_UPPER_BIT 7
`define MS_PULLDN_BIT 8
`define MS_USED_MSB 8
`define MS_RESET 16'h0000
`define CTRL_BP_EN_BIT 0
`define STAT_BUSY_BIT 0

// ------------------------------------------------------------
// sizes and timing
// ------------------------------------------------------------
`define CM_DEPTH 4096
`define CM_AW 12
`define CM_DW 16
`define NUM_STREAMS 32
`define HALF_STREAMS 16
`define CLK_PERIOD_NS 40
`define FRAME_TIME_NS 125000
`define FILL_FRAMES 2
`define FILL_CYCLES ((`FILL_FRAMES * `FRAME_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* src/mode_select.sv */
// mode select register bank with apb slave and connection memory block fill
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ims_regs.svh"

module mode_select #(
  parameter int FILL_CYCLES = `FILL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire mode_sel_pkg::stream_vec_t serial_in_stream,
  input wire mode_sel_pkg::stream_vec_t ber_rx_req,
  input wire mode_sel_pkg::stream_vec_t ber_tx_req,
  output mode_sel_pkg::stream_vec_t serial_in_gated_ff,
  output mode_sel_pkg::stream_vec_t serial_out_bidir_ff,
  output mode_sel_pkg::stream_vec_t ber_rx_run_ff,
  output mode_sel_pkg::stream_vec_t ber_tx_run_ff,
  output logic input_pulldown_enable_ff,
  output logic fill_busy_ff
);
  import mode_sel_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  word_t mode_ff;
  logic block_prog_enable_ff;
  logic wait_ff;
  fill_state_t state_ff;
  logic [`CM_AW-1:0] fill_addr_ff;
  logic walk_done_ff;
  logic [15:0] timer_ff;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire setup_cyc = psel & ~penable;
  // wait_ff marks the first access cycle of a transfer
  wire latch_cyc = psel & penable & wait_ff;
  wire done_xfer = psel & penable & pready_ff;
  wire hit_mode = (paddr == `ADDR_MODE_SEL);
  wire hit_ctrl = (paddr == `ADDR_CTRL);
  wire hit_stat = (paddr == `ADDR_STATUS);
  // misaligned window addresses fall through to unmapped
  wire hit_cm = paddr[`CM_WIN_BIT] & (paddr[1:0] == 2'b00);
  wire cm_high = paddr[`CM_HIGH_BIT];
  wire [`CM_AW-1:0] cm_idx = paddr[`CM_IDX_MSB:`CM_IDX_LSB];
  wire mapped = hit_mode | hit_ctrl | hit_stat | hit_cm;
  wire fill_active = (state_ff == FILL_RUN);
  // connection memory is owned by the fill while it runs
  wire cm_refused = hit_cm & fill_active;
  wire unmapped = ~mapped;
  // status is read only, so a write to it is refused
  wire stat_write = hit_stat & pwrite;
  wire bad_access = unmapped | cm_refused | stat_write;
  // a write lands only at the completing edge
  wire wr_ok = done_xfer & pwrite & ~bad_access;
  wire wr_mode = wr_ok & hit_mode;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_cm = wr_ok & hit_cm;

  // ------------------------------------------------------------
  // mode register write data with byte strobes
  // ------------------------------------------------------------
  wire [7:0] mode_lo = pstrb[0] ? pwdata[7:0] : mode_ff[7:0];
  wire mode_hi = pstrb[1] ? pwdata[`MS_USED_MSB] : mode_ff[`MS_USED_MSB];
  // bits 15 to 9 are reserved and read as zero
  wire [15:0] mode_wr = {7'h00, mode_hi, mode_lo};
  wire start_bit = mode_ff[`MS_START_BIT];
  wire [2:0] fill_value = mode_ff[`MS_VALUE_MSB:`MS_VALUE_LSB];
  // only a 0 to 1 write of start launches a fill
  wire start_rise = wr_mode & ~start_bit & mode_wr[`MS_START_BIT];
  wire start_kept = wr_mode ? mode_wr[`MS_START_BIT] : start_bit;
  wire ctrl_wr_bit = pwdata[`CTRL_BP_EN_BIT];
  wire enable_wr = pstrb[0] ? ctrl_wr_bit : block_prog_enable_ff;
  wire enable_kept = wr_ctrl ? enable_wr : block_prog_enable_ff;

  // ------------------------------------------------------------
  // mode fields seen by the stream side
  // ------------------------------------------------------------
  // a half in bidirectional mode ignores its serial inputs
  wire upper_bidir_ctrl = mode_ff[`MS_UPPER_BIT];
  wire lower_bidir_ctrl = mode_ff[`MS_LOWER_BIT];
  // the global enables gate every per-stream request
  wire pattern_rx_enable = mode_ff[`MS_RX_EN_BIT];
  wire pattern_tx_enable = mode_ff[`MS_TX_EN_BIT];

  // ------------------------------------------------------------
  // block fill sequencing
  // ------------------------------------------------------------
  wire timer_end = (timer_ff >= 16'(FILL_CYCLES - 1));
  wire last_addr = (fill_addr_ff == `CM_AW'(`CM_DEPTH - 1));
  // done when the frame timer and the walk have both ended
  wire fill_finish = fill_active & timer_end & (walk_done_ff | last_addr);
  // clearing start or enable aborts the fill
  wire abort = fill_active & (~start_kept | ~enable_kept);
  fill_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FILL_IDLE: begin
        if (start_rise) begin
          nxt_state = FILL_HOLD;
        end
      end
      FILL_HOLD: begin
        // start seen, waiting for the enable
        if (~start_kept) begin
          nxt_state = FILL_IDLE;
        end else if (enable_kept) begin
          nxt_state = FILL_RUN;
        end
      end
      FILL_RUN: begin
        // walk the memory until timer and walk both end
        if (abort | fill_finish) begin
          nxt_state = FILL_IDLE;
        end
      end
      default: begin
        nxt_state = FILL_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // block fill datapath
  // ------------------------------------------------------------
  // each entry is written once per fill
  wire fill_we = fill_active & ~walk_done_ff;
  // the fill value is read live from the mode register
  wire [15:0] fill_low = {13'h0000, fill_value};
  wire [15:0] fill_high = 16'h0000;
  // the timer saturates at its end so a slow walk still finishes cleanly
  wire [15:0] timer_inc = timer_ff + 16'h0001;
  wire [15:0] timer_step = timer_end ? timer_ff : timer_inc;
  wire [15:0] nxt_timer = fill_active ? timer_step : 16'h0000;
  wire [`CM_AW-1:0] fill_addr_inc = fill_addr_ff + `CM_AW'(1);
  wire [`CM_AW-1:0] fill_addr_hold = fill_active ? fill_addr_ff : `CM_AW'(0);
  wire [`CM_AW-1:0] nxt_fill_addr = fill_we ? fill_addr_inc : fill_addr_hold;
  wire nxt_walk_done = fill_active & (walk_done_ff | last_addr);
  wire [15:0] mode_cleared = mode_ff & ~16'h0001;
  // a software write to the start bit outranks the self-clear
  wire [15:0] nxt_mode = wr_mode ? mode_wr :
                         (fill_finish ? mode_cleared : mode_ff);
  wire nxt_pulldown = nxt_mode[`MS_PULLDN_BIT];
  wire nxt_busy = (nxt_state == FILL_RUN);

  // ------------------------------------------------------------
  // connection memory
  // ------------------------------------------------------------
  // the fill owns the memory port while it runs
  wire [`CM_AW-1:0] mem_addr = fill_active ? fill_addr_ff : cm_idx;
  wire cm_wr_low = wr_cm & ~cm_high;
  wire cm_wr_high = wr_cm & cm_high;
  wire mem_we_low = fill_we | cm_wr_low;
  wire mem_we_high = fill_we | cm_wr_high;
  wire [15:0] mem_wd_low = fill_active ? fill_low : pwdata[15:0];
  wire [15:0] mem_wd_high = fill_active ? fill_high : pwdata[15:0];
  wire [15:0] mem_rd_low;
  wire [15:0] mem_rd_high;

  cm_memory u_cm (
    .pclk(pclk),
    .addr(mem_addr),
    .we_low(mem_we_low),
    .we_high(mem_we_high),
    .wdata_low(mem_wd_low),
    .wdata_high(mem_wd_high),
    .rdata_low(mem_rd_low),
    .rdata_high(mem_rd_high)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [15:0] cm_rd = cm_high ? mem_rd_high : mem_rd_low;
  wire [31:0] rd_mode = {16'h0000, mode_ff};
  wire [31:0] rd_ctrl = {31'h0000_0000, block_prog_enable_ff};
  wire [31:0] rd_stat = {31'h0000_0000, fill_active};
  wire [31:0] rd_cm = {16'h0000, cm_rd};
  // refused transfers read as zero
  wire [31:0] rd_word = bad_access ? 32'h0000_0000 :
                        hit_mode ? rd_mode :
                        hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat :
                        rd_cm;

  // ------------------------------------------------------------
  // apb response
  // ------------------------------------------------------------
  // every transfer gets one wait state: ready follows the first access edge
  wire nxt_ready = latch_cyc;
  wire nxt_err = latch_cyc & bad_access;
  // a write answers zero so no stale word is left on the bus
  wire [31:0] nxt_rdata = pwrite ? 32'h0000_0000 : rd_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      wait_ff <= setup_cyc;
      pready_ff <= nxt_ready;
      pslverr_ff <= nxt_err;
    end
  end

  // read data holds between transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (latch_cyc) begin
      prdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // mode, control and fill state registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `MS_RESET;
      block_prog_enable_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      block_prog_enable_ff <= enable_kept;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FILL_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff <= 16'h0000;
      fill_addr_ff <= `CM_AW'(0);
      walk_done_ff <= 1'b0;
    end else begin
      timer_ff <= nxt_timer;
      fill_addr_ff <= nxt_fill_addr;
      walk_done_ff <= nxt_walk_done;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_pulldown_enable_ff <= 1'b0;
      fill_busy_ff <= 1'b0;
    end else begin
      input_pulldown_enable_ff <= nxt_pulldown;
      fill_busy_ff <= nxt_busy;
    end
  end

  // ------------------------------------------------------------
  // stream side
  // ------------------------------------------------------------
  // gating registers live in the per-stream generate loop
  stream_ctrl u_streams (
    .pclk(pclk),
    .presetn(presetn),
    .upper_bidir_ctrl(upper_bidir_ctrl),
    .lower_bidir_ctrl(lower_bidir_ctrl),
    .pattern_rx_enable(pattern_rx_enable),
    .pattern_tx_enable(pattern_tx_enable),
    .serial_in_stream(serial_in_stream),
    .ber_rx_req(ber_rx_req),
    .ber_tx_req(ber_tx_req),
    .serial_in_gated_ff(serial_in_gated_ff),
    .serial_out_bidir_ff(serial_out_bidir_ff),
    .ber_rx_run_ff(ber_rx_run_ff),
    .ber_tx_run_ff(ber_tx_run_ff)
  );
endmodule

/* src/stream_ctrl.sv */
// per-stream input gating, bidirectional mode and pattern test enables
`timescale 1ns/1ps
`include "ims_regs.svh"
module stream_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic upper_bidir_ctrl,
  input wire logic lower_bidir_ctrl,
  input wire logic pattern_rx_enable,
  input wire logic pattern_tx_enable,
  input wire mode_sel_pkg::stream_vec_t serial_in_stream,
  input wire mode_sel_pkg::stream_vec_t ber_rx_req,
  input wire mode_sel_pkg::stream_vec_t ber_tx_req,
  output mode_sel_pkg::stream_vec_t serial_in_gated_ff,
  output mode_sel_pkg::stream_vec_t serial_out_bidir_ff,
  output mode_sel_pkg::stream_vec_t ber_rx_run_ff,
  output mode_sel_pkg::stream_vec_t ber_tx_run_ff
);
  import mode_sel_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `NUM_STREAMS; i++) begin : g_stream
      wire bidir = (i >= `HALF_STREAMS) ? upper_bidir_ctrl : lower_bidir_ctrl;
      wire nxt_in = serial_in_stream[i] & ~bidir;
      wire nxt_rx = ber_rx_req[i] & pattern_rx_enable;
      wire nxt_tx = ber_tx_req[i] & pattern_tx_enable;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          serial_in_gated_ff[i] <= 1'b0;
          serial_out_bidir_ff[i] <= 1'b0;
          ber_rx_run_ff[i] <= 1'b0;
          ber_tx_run_ff[i] <= 1'b0;
        end else begin
          serial_in_gated_ff[i] <= nxt_in;
          serial_out_bidir_ff[i] <= bidir;
          ber_rx_run_ff[i] <= nxt_rx;
          ber_tx_run_ff[i] <= nxt_tx;
        end
      end
    end
  endgenerate
endmodule

/* tb/mode_select_chk.sv */
// concurrent checks on the ports of the mode select block
`timescale 1ns/1ps
module mode_select_chk #(
  parameter int FILL_CYCLES = 6250
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire mode_sel_pkg::stream_vec_t serial_in_stream,
  input wire mode_sel_pkg::stream_vec_t ber_rx_req,
  input wire mode_sel_pkg::stream_vec_t ber_tx_req,
  input wire mode_sel_pkg::stream_vec_t serial_in_gated_ff,
  input wire mode_sel_pkg::stream_vec_t serial_out_bidir_ff,
  input wire mode_sel_pkg::stream_vec_t ber_rx_run_ff,
  input wire mode_sel_pkg::stream_vec_t ber_tx_run_ff,
  input wire logic fill_busy_ff
);
  import mode_sel_pkg::*;
  int busy_cnt_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // fill length counter and assertions
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= fill_busy_ff ? busy_cnt_ff + 1 : 0;
    end
  end
  a_upper_gate_low: assert property (|serial_in_gated_ff[31:16] |-> serial_out_bidir_ff[31:16] == 16'h0000)
    else $error("upper inputs pass while bidirectional");
  a_upper_whole_half: assert property (serial_out_bidir_ff[31:16] inside {16'h0000, 16'hffff})
    else $error("upper half mode split");
  a_lower_pass_input: assert property ($past(presetn) && serial_out_bidir_ff[15:0] == 16'h0000
    |-> serial_in_gated_ff[15:0] == $past(serial_in_stream[15:0])) else $error("lower inputs not passed");
  a_rx_gate_req: assert property ((ber_rx_run_ff & ~$past(ber_rx_req)) == 32'h0)
    else $error("receiver runs without request");
  a_tx_gate_req: assert property ((ber_tx_run_ff & ~$past(ber_tx_req)) == 32'h0)
    else $error("transmitter runs without request");
  a_apb_one_wait: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("apb answer late");
  a_ready_one_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  a_fill_len_bound: assert property (busy_cnt_ff <= FILL_CYCLES + 2)
    else $error("fill runs too long");
endmodule
bind mode_select mode_select_chk #(.FILL_CYCLES(FILL_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .serial_in_stream(serial_in_stream),
  .ber_rx_req(ber_rx_req), .ber_tx_req(ber_tx_req), .serial_in_gated_ff(serial_in_gated_ff),
  .serial_out_bidir_ff(serial_out_bidir_ff), .ber_rx_run_ff(ber_rx_run_ff), .ber_tx_run_ff(ber_tx_run_ff),
  .fill_busy_ff(fill_busy_ff));

/* tb/mode_select_tb.sv */
// self-checking bench for the mode select block
`timescale 1ns/1ps
module tdm_switch_mode_select_register_tb_top;
  import mode_sel_pkg::*;
  localparam int FILL_N = 4100;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, input_pulldown_enable_ff, fill_busy_ff, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata_ff, rd;
  stream_vec_t serial_in_stream, ber_rx_req, ber_tx_req, serial_in_gated_ff, serial_out_bidir_ff;
  stream_vec_t ber_rx_run_ff, ber_tx_run_ff;
  int err_total, n_tests;
  mode_select #(.FILL_CYCLES(FILL_N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .serial_in_stream(serial_in_stream), .ber_rx_req(ber_rx_req), .ber_tx_req(ber_tx_req),
    .serial_in_gated_ff(serial_in_gated_ff), .serial_out_bidir_ff(serial_out_bidir_ff),
    .ber_rx_run_ff(ber_rx_run_ff), .ber_tx_run_ff(ber_tx_run_ff),
    .input_pulldown_enable_ff(input_pulldown_enable_ff), .fill_busy_ff(fill_busy_ff));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 20);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, exp_err});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rchk(16'h0000, 32'h0000_0000, 1'b0);
    apb(1'b1, 16'h0000, 32'hffff_fffe);
    rchk(16'h0000, 32'h0000_01fe, 1'b0);
    chk({31'h0, input_pulldown_enable_ff}, 32'h1);
    apb(1'b1, 16'h0000, 32'h0);
    rchk(16'h0100, 32'h0, 1'b1);
    apb(1'b1, 16'h0008, 32'h1);
    chk({31'h0, er}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_modes;
    serial_in_stream <= 32'hffff_ffff;
    ber_rx_req <= 32'hffff_ffff;
    ber_tx_req <= 32'h5a5a_0ff0;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 16'h0000, (m << 6) | (m << 4));
      repeat (2) @(posedge pclk);
      chk(serial_out_bidir_ff, {{16{m[1]}}, {16{m[0]}}});
      chk(serial_in_gated_ff, ~{{16{m[1]}}, {16{m[0]}}});
      chk(ber_rx_run_ff, m[1] ? 32'hffff_ffff : 32'h0);
      chk(ber_tx_run_ff, m[0] ? 32'h5a5a_0ff0 : 32'h0);
    end
    $display("test modes done");
  endtask
  task automatic t_fill;
    int n;
    apb(1'b1, 16'h8000, 32'hffff);
    apb(1'b1, 16'hfffc, 32'hffff);
    apb(1'b1, 16'h0004, 32'h1);
    apb(1'b1, 16'h0000, 32'h0000_000b); // start and value in one write
    rchk(16'h8004, 32'h0, 1'b1);
    chk({31'h0, fill_busy_ff}, 32'h1);
    n = 0;
    do begin
      apb(1'b0, 16'h0008, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      end_of_test();
    end
    rchk(16'h0000, 32'h0000_000a, 1'b0);
    rchk(16'h8000, 32'h0000_0005, 1'b0);
    rchk(16'hbffc, 32'h0000_0005, 1'b0);
    rchk(16'hfffc, 32'h0, 1'b0);
    $display("test fill done");
  endtask
  task automatic t_abort;
    apb(1'b1, 16'h0000, 32'h0000_0007);
    repeat (10) @(posedge pclk);
    chk({31'h0, fill_busy_ff}, 32'h1);
    apb(1'b1, 16'h0000, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    chk({31'h0, fill_busy_ff}, 32'h0);
    apb(1'b1, 16'h0000, 32'h0000_0007);
    repeat (10) @(posedge pclk);
    apb(1'b1, 16'h0004, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, fill_busy_ff}, 32'h0);
    rchk(16'h0000, 32'h0000_0007, 1'b0);
    $display("test abort done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    serial_in_stream = 32'h0;
    ber_rx_req = 32'h0;
    ber_tx_req = 32'h0;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_fill();
    t_abort();
    end_of_test();
  end
endmodule
